//--- rtl/urm_pkg.sv
// Operation
// - normal bank 0x00 reads receive byte, writes transmit byte.
// - divisor bank: 0x00/0x01 are divisor low/high.
// - 0x02 fraction needs divisor bank and enhanced enable.
// - normal read of 0x02 gives fifo enables and irq source.
// - normal write of 0x02 loads fifo_control.
// - key 0xBF: 0x02 enhanced_function, 0x04-0x07 flow chars.
// - enhanced bits are zero unless enhanced enable set.
// - irq_enable at 0x01 holds eight enables.
// - line_control at 0x03 read/write in every bank.
// - modem_control at 0x04 drives modem outputs and selects.
// - line_status at 0x05 read-only, hidden under key.
// - modem_status at 0x06: change flags and input states.
// - flow_threshold at 0x06: halt low, resume high nibble.
// - fifo_trigger_levels at 0x07: transmit low, receive high.
// - scratch_byte at 0x07 returns any written value.
// - 0x08/0x09 fill counts in bits 6:0, bit 7 zero.
// - pin registers 0x0A, 0x0C, 0x0E, 0x0F; 0x0D reads zero.
// - pin_state at 0x0B only while line_control bit 7 clear.
package urm_pkg;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int FILL_W = 7;
   localparam int MODEM_W = 4;
   localparam int EV_W = 3;
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_HOLDING = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 5'h01;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 5'h02;
   localparam logic [ADDR_W-1:0] OFF_LINE_CONTROL = 5'h03;
   localparam logic [ADDR_W-1:0] OFF_MODEM_CONTROL = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_LINE_STATUS = 5'h05;
   localparam logic [ADDR_W-1:0] OFF_MODEM_STATUS = 5'h06;
   localparam logic [ADDR_W-1:0] OFF_SCRATCH = 5'h07;
   localparam logic [ADDR_W-1:0] OFF_TX_FILL = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_RX_FILL = 5'h09;
   localparam logic [ADDR_W-1:0] OFF_PIN_DIRECTION = 5'h0A;
   localparam logic [ADDR_W-1:0] OFF_PIN_STATE = 5'h0B;
   localparam logic [ADDR_W-1:0] OFF_PIN_IRQ_ENABLE = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_PIN_IO_CONTROL = 5'h0E;
   localparam logic [ADDR_W-1:0] OFF_EXTRA_FEATURE = 5'h0F;
   localparam logic [ADDR_W-1:0] OFF_EVENT_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 5'h11;
   // ----------------------------------------------------------------
   // field positions, keys, masks, reset value
   // ----------------------------------------------------------------
   localparam logic [DATA_W-1:0] ENH_BANK_KEY = 8'hBF;
   localparam int LCR_DIV_BIT = 7;
   localparam int EFR_ENH_BIT = 4;
   localparam int MCR_DTR_BIT = 0;
   localparam int MCR_RTS_BIT = 1;
   localparam int MCR_OP1_BIT = 2;
   localparam int MCR_OP2_BIT = 3;
   localparam int MCR_LOOP_BIT = 4;
   localparam int FCR_EN_BIT = 0;
   localparam int FCR_RXRST_BIT = 1;
   localparam int FCR_TXRST_BIT = 2;
   localparam logic [DATA_W-1:0] IER_ENH_MASK = 8'hF0;
   localparam logic [DATA_W-1:0] FCR_ENH_MASK = 8'h30;
   localparam logic [DATA_W-1:0] FCR_KEEP_MASK = 8'hF1;
   localparam logic [DATA_W-1:0] MCR_ENH_MASK = 8'hE0;
   localparam logic [5:0] ISR_ENH_MASK = 6'h30;
   localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
   localparam int EV_MODEM = 0;
   localparam int EV_PIN = 1;
   localparam int EV_CORE = 2;
endpackage

//--- rtl/urm_sync2.sv
`timescale 1ns/1ns
// two-flop synchroniser; only stage two may be read by logic
module urm_sync2 #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } urm_sync_s;
   urm_sync_s st_r;
   urm_sync_s st_nxt;

   // shift the pin level through both stages
   always_comb
   begin
      st_nxt.stage1 = async_in;
      st_nxt.stage2 = st_r.stage1;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign sync_out = st_r.stage2;
endmodule

//--- rtl/urm_sticky.sv
`timescale 1ns/1ns
// sticky flags; set beats clear
module urm_sticky #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [W-1:0] set_in,
   input wire logic [W-1:0] clr_in,
   output logic [W-1:0] flags
);
   typedef struct packed {
      logic [W-1:0] flag;
   } urm_sticky_s;
   urm_sticky_s st_r;
   urm_sticky_s st_nxt;

   // clear, then set, so no event is lost
   always_comb
   begin
      st_nxt.flag = (st_r.flag & ~clr_in) | set_in;
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign flags = st_r.flag;
endmodule

//--- rtl/urm_regs.sv
`timescale 1ns/1ns
// uart register file with banked decode and event interrupt
module urm_regs (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [urm_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [urm_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [urm_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [urm_pkg::DATA_W-1:0] rx_holding_in,
   input wire logic [urm_pkg::DATA_W-1:0] line_status_in,
   input wire logic [5:0] irq_source_in,
   input wire logic [urm_pkg::FILL_W-1:0] tx_fill_in,
   input wire logic [urm_pkg::FILL_W-1:0] rx_fill_in,
   input wire logic clear_to_send_in,
   input wire logic set_ready_in,
   input wire logic ring_in,
   input wire logic carrier_in,
   input wire logic [urm_pkg::DATA_W-1:0] pin_in,
   output logic [urm_pkg::DATA_W-1:0] tx_data,
   output logic tx_load,
   output logic rx_pop,
   output logic rx_fifo_reset,
   output logic tx_fifo_reset,
   output logic fifo_enable,
   output logic [urm_pkg::DATA_W-1:0] line_control_out,
   output logic [15:0] baud_divisor,
   output logic [urm_pkg::DATA_W-1:0] baud_fraction,
   output logic terminal_ready_out,
   output logic request_send_out,
   output logic loopback_out,
   output logic [urm_pkg::DATA_W-1:0] pin_out,
   output logic [urm_pkg::DATA_W-1:0] pin_oe,
   output logic irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] line_control;
      logic [7:0] div_low;
      logic [7:0] div_high;
      logic [7:0] div_fraction;
      logic [7:0] irq_enable;
      logic [7:0] fifo_control;
      logic [7:0] enhanced_function;
      logic [7:0] modem_control;
      logic [7:0] resume_char_1;
      logic [7:0] resume_char_2;
      logic [7:0] stop_char_1;
      logic [7:0] stop_char_2;
      logic [7:0] scratch_byte;
      logic [7:0] flow_threshold;
      logic [7:0] trigger_levels;
      logic [7:0] pin_direction;
      logic [7:0] pin_state;
      logic [7:0] pin_irq_enable;
      logic [7:0] pin_io_control;
      logic [7:0] extra_feature;
      logic [urm_pkg::EV_W-1:0] event_mask;
      logic [3:0] modem_prev;
      logic [7:0] pin_prev;
      logic [7:0] rdata;
      logic [7:0] tx_data;
      logic tx_load;
      logic rx_pop;
      logic rx_reset;
      logic tx_reset;
      logic irq;
   } urm_regs_s;
   urm_regs_s st_r;
   urm_regs_s st_nxt;

   logic [11:0] pins_sync;
   logic [3:0] modem_sync;
   logic [7:0] pin_sync;
   logic [3:0] modem_now;
   logic [3:0] delta_set;
   logic [3:0] delta_clr;
   logic [3:0] delta_flags;
   logic [urm_pkg::EV_W-1:0] ev_set;
   logic [urm_pkg::EV_W-1:0] ev_clr;
   logic [urm_pkg::EV_W-1:0] ev_flags;
   logic bank_enh;
   logic bank_div;
   logic bank_norm;
   logic enh_on;
   logic trig_sel;
   logic [7:0] rd_val;
   logic [7:0] ier_wmask;
   logic [7:0] fcr_wmask;
   logic [7:0] mcr_wmask;
   logic [7:0] pin_read;
   logic [7:0] pin_changed;

   // ----------------------------------------------------------------
   // pin synchronisers and sticky flags
   // ----------------------------------------------------------------
   // pins are asynchronous to clock
   urm_sync2 #(
      .W(12)
   ) u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in({pin_in, carrier_in, ring_in, set_ready_in, clear_to_send_in}),
      .sync_out(pins_sync)
   );
   assign modem_sync = pins_sync[3:0];
   assign pin_sync = pins_sync[11:4];

   // modem change flags, cleared by reading modem status
   urm_sticky #(
      .W(4)
   ) u_delta (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(delta_set),
      .clr_in(delta_clr),
      .flags(delta_flags)
   );

   // interrupt event flags, cleared by writing one
   urm_sticky #(
      .W(urm_pkg::EV_W)
   ) u_events (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(ev_set),
      .clr_in(ev_clr),
      .flags(ev_flags)
   );

   // ----------------------------------------------------------------
   // bank decode from the current line_control value
   // ----------------------------------------------------------------
   always_comb
   begin
      bank_enh = (st_r.line_control == urm_pkg::ENH_BANK_KEY);
      bank_div = st_r.line_control[urm_pkg::LCR_DIV_BIT] && !bank_enh;
      bank_norm = !st_r.line_control[urm_pkg::LCR_DIV_BIT];
      enh_on = st_r.enhanced_function[urm_pkg::EFR_ENH_BIT];
      trig_sel = st_r.modem_control[urm_pkg::MCR_OP1_BIT];
      // enhanced bits lost while disabled
      ier_wmask = enh_on ? 8'hFF : ~urm_pkg::IER_ENH_MASK;
      fcr_wmask = urm_pkg::FCR_KEEP_MASK & (enh_on ? 8'hFF : ~urm_pkg::FCR_ENH_MASK);
      mcr_wmask = enh_on ? 8'hFF : ~urm_pkg::MCR_ENH_MASK;
   end

   // ----------------------------------------------------------------
   // modem inputs, loopback and pin change detect
   // ----------------------------------------------------------------
   // loopback ignores the modem pins
   always_comb
   begin
      if (st_r.modem_control[urm_pkg::MCR_LOOP_BIT])
      begin
         modem_now = {st_r.modem_control[urm_pkg::MCR_OP2_BIT],
                      st_r.modem_control[urm_pkg::MCR_OP1_BIT],
                      st_r.modem_control[urm_pkg::MCR_DTR_BIT],
                      st_r.modem_control[urm_pkg::MCR_RTS_BIT]};
      end
      else
      begin
         modem_now = modem_sync;
      end
      delta_set = modem_now ^ st_r.modem_prev;
      pin_changed = (pin_sync ^ st_r.pin_prev) & ~st_r.pin_direction;
      ev_set = '0;
      ev_set[urm_pkg::EV_MODEM] = |delta_set;
      ev_set[urm_pkg::EV_PIN] = |(pin_changed & st_r.pin_irq_enable);
      // core event re-sets while pending
      ev_set[urm_pkg::EV_CORE] = !irq_source_in[0];
      // inputs show pin, outputs latch
      pin_read = (st_r.pin_state & st_r.pin_direction) | (pin_sync & ~st_r.pin_direction);
   end

   // ----------------------------------------------------------------
   // register access: read mux and write effects
   // ----------------------------------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.tx_load = 1'b0;
      st_nxt.rx_pop = 1'b0;
      st_nxt.rx_reset = 1'b0;
      st_nxt.tx_reset = 1'b0;
      st_nxt.modem_prev = modem_now;
      st_nxt.pin_prev = pin_sync;
      delta_clr = '0;
      ev_clr = '0;
      rd_val = '0;
      unique case (reg_addr)
         urm_pkg::OFF_HOLDING:
         begin
            if (bank_norm)
            begin
               rd_val = rx_holding_in;
               st_nxt.rx_pop = reg_rd;
               if (reg_wr)
               begin
                  st_nxt.tx_data = reg_wdata;
                  st_nxt.tx_load = 1'b1;
               end
            end
            else if (bank_div)
            begin
               rd_val = st_r.div_low;
               if (reg_wr)
                  st_nxt.div_low = reg_wdata;
            end
         end
         urm_pkg::OFF_IRQ_ENABLE:
         begin
            if (bank_norm)
            begin
               rd_val = st_r.irq_enable & ier_wmask;
               if (reg_wr)
                  st_nxt.irq_enable = reg_wdata & ier_wmask;
            end
            else if (bank_div)
            begin
               rd_val = st_r.div_high;
               if (reg_wr)
                  st_nxt.div_high = reg_wdata;
            end
         end
         urm_pkg::OFF_IRQ_STATUS:
         begin
            if (bank_norm)
            begin
               rd_val = {{2{st_r.fifo_control[urm_pkg::FCR_EN_BIT]}},
                         irq_source_in & (enh_on ? 6'h3F : ~urm_pkg::ISR_ENH_MASK)};
               if (reg_wr)
               begin
                  st_nxt.fifo_control = reg_wdata & fcr_wmask;
                  st_nxt.rx_reset = reg_wdata[urm_pkg::FCR_RXRST_BIT];
                  st_nxt.tx_reset = reg_wdata[urm_pkg::FCR_TXRST_BIT];
               end
            end
            else if (bank_enh)
            begin
               rd_val = st_r.enhanced_function;
               if (reg_wr)
                  st_nxt.enhanced_function = reg_wdata;
            end
            else if (enh_on)
            begin
               rd_val = st_r.div_fraction;
               if (reg_wr)
                  st_nxt.div_fraction = reg_wdata;
            end
         end
         urm_pkg::OFF_LINE_CONTROL:
         begin
            rd_val = st_r.line_control;
            if (reg_wr)
               st_nxt.line_control = reg_wdata;
         end
         urm_pkg::OFF_MODEM_CONTROL:
         begin
            if (bank_enh)
            begin
               rd_val = st_r.resume_char_1;
               if (reg_wr)
                  st_nxt.resume_char_1 = reg_wdata;
            end
            else
            begin
               rd_val = st_r.modem_control & mcr_wmask;
               if (reg_wr)
                  st_nxt.modem_control = reg_wdata & mcr_wmask;
            end
         end
         urm_pkg::OFF_LINE_STATUS:
         begin
            if (bank_enh)
            begin
               rd_val = st_r.resume_char_2;
               if (reg_wr)
                  st_nxt.resume_char_2 = reg_wdata;
            end
            else
            begin
               rd_val = line_status_in;
            end
         end
         urm_pkg::OFF_MODEM_STATUS:
         begin
            if (bank_enh)
            begin
               rd_val = st_r.stop_char_1;
               if (reg_wr)
                  st_nxt.stop_char_1 = reg_wdata;
            end
            else if (trig_sel)
            begin
               rd_val = st_r.flow_threshold;
               if (reg_wr)
                  st_nxt.flow_threshold = reg_wdata;
            end
            else
            begin
               rd_val = {modem_now, delta_flags};
               delta_clr = {4{reg_rd}};
            end
         end
         urm_pkg::OFF_SCRATCH:
         begin
            if (bank_enh)
            begin
               rd_val = st_r.stop_char_2;
               if (reg_wr)
                  st_nxt.stop_char_2 = reg_wdata;
            end
            else if (trig_sel)
            begin
               rd_val = st_r.trigger_levels;
               if (reg_wr)
                  st_nxt.trigger_levels = reg_wdata;
            end
            else
            begin
               rd_val = st_r.scratch_byte;
               if (reg_wr)
                  st_nxt.scratch_byte = reg_wdata;
            end
         end
         urm_pkg::OFF_TX_FILL:
            rd_val = {1'b0, tx_fill_in};
         urm_pkg::OFF_RX_FILL:
            rd_val = {1'b0, rx_fill_in};
         urm_pkg::OFF_PIN_DIRECTION:
         begin
            rd_val = st_r.pin_direction;
            if (reg_wr)
               st_nxt.pin_direction = reg_wdata;
         end
         urm_pkg::OFF_PIN_STATE:
         begin
            if (bank_norm)
            begin
               rd_val = pin_read;
               if (reg_wr)
                  st_nxt.pin_state = reg_wdata;
            end
         end
         urm_pkg::OFF_PIN_IRQ_ENABLE:
         begin
            rd_val = st_r.pin_irq_enable;
            if (reg_wr)
               st_nxt.pin_irq_enable = reg_wdata;
         end
         urm_pkg::OFF_PIN_IO_CONTROL:
         begin
            rd_val = st_r.pin_io_control;
            if (reg_wr)
               st_nxt.pin_io_control = reg_wdata;
         end
         urm_pkg::OFF_EXTRA_FEATURE:
         begin
            rd_val = st_r.extra_feature;
            if (reg_wr)
               st_nxt.extra_feature = reg_wdata;
         end
         urm_pkg::OFF_EVENT_STATUS:
         begin
            rd_val = {{(8 - urm_pkg::EV_W){1'b0}}, ev_flags};
            if (reg_wr)
               ev_clr = reg_wdata[urm_pkg::EV_W-1:0];
         end
         urm_pkg::OFF_EVENT_MASK:
         begin
            rd_val = {{(8 - urm_pkg::EV_W){1'b0}}, st_r.event_mask};
            if (reg_wr)
               st_nxt.event_mask = reg_wdata[urm_pkg::EV_W-1:0];
         end
         // reserved and unmapped read zero
         default:
            rd_val = '0;
      endcase
      // read data stand only in the cycle after the strobe
      st_nxt.rdata = reg_rd ? rd_val : urm_pkg::RESET_BYTE;
      // level interrupt from any unmasked sticky event
      st_nxt.irq = |(ev_flags & st_r.event_mask);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // no reset values given; all start cleared
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------------------------------
   // outputs, all straight from the state register
   // ----------------------------------------------------------------
   assign reg_rdata = st_r.rdata;
   assign tx_data = st_r.tx_data;
   assign tx_load = st_r.tx_load;
   assign rx_pop = st_r.rx_pop;
   assign rx_fifo_reset = st_r.rx_reset;
   assign tx_fifo_reset = st_r.tx_reset;
   assign fifo_enable = st_r.fifo_control[urm_pkg::FCR_EN_BIT];
   assign line_control_out = st_r.line_control;
   assign baud_divisor = {st_r.div_high, st_r.div_low};
   assign baud_fraction = st_r.div_fraction;
   assign terminal_ready_out = st_r.modem_control[urm_pkg::MCR_DTR_BIT];
   assign request_send_out = st_r.modem_control[urm_pkg::MCR_RTS_BIT];
   assign loopback_out = st_r.modem_control[urm_pkg::MCR_LOOP_BIT];
   assign pin_out = st_r.pin_state;
   assign pin_oe = st_r.pin_direction;
   assign irq = st_r.irq;
endmodule

//--- dv/urm_core_model.sv
`timescale 1ns/1ns
// stand-in for the uart core behind the register file
module urm_core_model (
   input logic clock,
   input logic sys_rst,
   input logic tx_load,
   input logic rx_pop,
   input logic rx_fifo_reset,
   input logic tx_fifo_reset,
   output logic [7:0] rx_holding_in,
   output logic [6:0] tx_fill_in,
   output logic [6:0] rx_fill_in
);
   // receive byte moves one edge after pop
   always @(posedge clock)
   begin
      if (sys_rst || rx_fifo_reset)
      begin
         rx_holding_in <= 8'h5A;
         rx_fill_in <= 7'h40;
      end
      else if (rx_pop && rx_fill_in != 7'h00)
      begin
         rx_holding_in <= rx_holding_in * 8'h05 + 8'h03;
         rx_fill_in <= rx_fill_in - 7'h01;
      end
      // transmit count saturates at a full fifo
      if (sys_rst || tx_fifo_reset)
         tx_fill_in <= 7'h00;
      else if (tx_load && tx_fill_in < 7'h40)
         tx_fill_in <= tx_fill_in + 7'h01;
   end
endmodule

//--- dv/urm_regs_asserts.sv
`timescale 1ns/1ns
// port watcher; bank from held line_control
module urm_regs_asserts (
   input logic clock,
   input logic sys_rst,
   input logic [4:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   input logic [7:0] reg_rdata,
   input logic [7:0] rx_holding_in,
   input logic [7:0] line_status_in,
   input logic [6:0] tx_fill_in,
   input logic [7:0] tx_data,
   input logic tx_load,
   input logic rx_pop,
   input logic rx_fifo_reset,
   input logic fifo_enable,
   input logic [7:0] line_control_out,
   input logic [15:0] baud_divisor,
   input logic terminal_ready_out,
   input logic irq
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   logic nb;
   logic div;
   // bank flags from the held line_control
   assign nb = !line_control_out[7];
   assign div = line_control_out[7] && line_control_out != urm_pkg::ENH_BANK_KEY;
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   chk_tx_write: assert property (
      reg_wr && reg_addr == 5'h00 && nb |=> tx_load && tx_data == $past(reg_wdata))
      else $error("transmit byte not passed on");
   chk_rx_read: assert property (
      reg_rd && reg_addr == 5'h00 && nb |=> rx_pop && reg_rdata == $past(rx_holding_in))
      else $error("receive byte read wrong");
   chk_pop_cause: assert property (rx_pop |-> $past(reg_rd && reg_addr == 5'h00 && nb))
      else $error("pop without receive read");
   chk_div_low: assert property (
      reg_wr && reg_addr == 5'h00 && div |=> baud_divisor[7:0] == $past(reg_wdata))
      else $error("divisor low not loaded");
   chk_lcr_write: assert property (
      reg_wr && reg_addr == 5'h03 |=> line_control_out == $past(reg_wdata))
      else $error("line control not loaded");
   chk_fifo_ctrl: assert property (
      reg_wr && reg_addr == 5'h02 && nb |=> fifo_enable == $past(reg_wdata[0])
      && rx_fifo_reset == $past(reg_wdata[1]))
      else $error("fifo control write wrong");
   chk_mcr_out: assert property (
      reg_wr && reg_addr == 5'h04 && line_control_out != 8'hBF
      |=> terminal_ready_out == $past(reg_wdata[0]))
      else $error("terminal ready not driven");
   chk_lsr_read: assert property (
      reg_rd && reg_addr == 5'h05 && line_control_out != 8'hBF
      |=> reg_rdata == $past(line_status_in))
      else $error("line status read wrong");
   chk_fill_read: assert property (
      reg_rd && reg_addr == 5'h08 |=> reg_rdata == {1'b0, $past(tx_fill_in)})
      else $error("fill count read wrong");
   chk_rsvd_zero: assert property (reg_rd && reg_addr == 5'h0D |=> reg_rdata == 8'h00)
      else $error("reserved slot not zero");
   cover property (tx_load);
   cover property (rx_pop);
   cover property (reg_wr && reg_addr == 5'h00 && div);
   cover property ($rose(irq));
endmodule
bind urm_regs urm_regs_asserts urm_regs_asserts_i (.clock, .sys_rst, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .rx_holding_in, .line_status_in, .tx_fill_in, .tx_data,
   .tx_load, .rx_pop, .rx_fifo_reset, .fifo_enable, .line_control_out, .baud_divisor,
   .terminal_ready_out, .irq);

//--- dv/uart_register_map_decode_bench.sv
`timescale 1ns/1ns
module uart_register_map_decode_bench;
   logic clock, sys_rst, reg_wr, reg_rd, tx_load, rx_pop, rx_fifo_reset, tx_fifo_reset;
   logic fifo_enable, terminal_ready_out, request_send_out, loopback_out, irq;
   logic clear_to_send_in, set_ready_in, ring_in, carrier_in;
   logic [4:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rx_holding_in, line_status_in, pin_in, tx_data;
   logic [7:0] line_control_out, baud_fraction, pin_out, pin_oe;
   logic [5:0] irq_source_in, sv;
   logic [6:0] tx_fill_in, rx_fill_in;
   logic [15:0] baud_divisor;
   logic [3:0] pv;
   logic [7:0] sh [0:31];
   int err_count, n_compared, seed, pk, pa, pd, pe, msx, k, a, d;
   bit rnd;
   urm_regs urm_regs_i (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .rx_holding_in, .line_status_in, .irq_source_in, .tx_fill_in, .rx_fill_in,
      .clear_to_send_in, .set_ready_in, .ring_in, .carrier_in, .pin_in, .tx_data, .tx_load,
      .rx_pop, .rx_fifo_reset, .tx_fifo_reset, .fifo_enable, .line_control_out,
      .baud_divisor, .baud_fraction, .terminal_ready_out, .request_send_out, .loopback_out,
      .pin_out, .pin_oe, .irq);
   urm_core_model urm_core_model_i (.clock, .sys_rst, .tx_load, .rx_pop, .rx_fifo_reset,
      .tx_fifo_reset, .rx_holding_in, .tx_fill_in, .rx_fill_in);
   // free-running clock
   initial
   begin
      clock = 0;
      forever #5 clock = ~clock;
   end
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cmp(logic [7:0] got, logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   // expected read; -1 = not predicted
   function automatic int ex(int a);
      logic [7:0] l;
      bit b, v, e, m;
      l = sh[3];
      b = (l == 8'hBF);
      v = l[7] && !b;
      e = sh[19][4];
      m = sh[4][2];
      case (a)
         0: return b ? 0 : v ? sh[16] : rx_holding_in;
         1: return b ? 0 : v ? sh[17] : sh[1] & (e ? 8'hFF : 8'h0F);
         2: return b ? sh[19] : v ? (e ? sh[18] : 0)
            : {sh[2][0], sh[2][0], irq_source_in & (e ? 6'h3F : 6'h0F)};
         4: return b ? sh[20] : sh[4] & (e ? 8'hFF : 8'h1F);
         5: return b ? sh[21] : line_status_in;
         6: return b ? sh[22] : m ? sh[24] : msx;
         7: return b ? sh[23] : m ? sh[25] : sh[7];
         8: return tx_fill_in;
         9: return rx_fill_in;
         11: return l[7] ? 0 : -1;
         13: return 0;
         16, 17: return -1;
         default: return sh[a];
      endcase
   endfunction
   // shadow write, bank as before it
   task automatic wa(int a, logic [7:0] d);
      bit b, v, e, m;
      b = (sh[3] == 8'hBF);
      v = sh[3][7] && !b;
      e = sh[19][4];
      m = sh[4][2];
      case (a)
         0: if (v) sh[16] = d;
         1: if (v) sh[17] = d; else if (!b) sh[1] = d & (e ? 8'hFF : 8'h0F);
         2: if (b) sh[19] = d; else if (!v) sh[2] = d; else if (e) sh[18] = d;
         3: sh[3] = d;
         4: if (b) sh[20] = d; else sh[4] = d & (e ? 8'hFF : 8'h1F);
         5: if (b) sh[21] = d;
         6: if (b) sh[22] = d; else if (m) sh[24] = d;
         7: if (b) sh[23] = d; else if (m) sh[25] = d; else sh[7] = d;
         10, 12, 14, 15: sh[a] = d;
         default: ;
      endcase
   endtask
   // one bus cycle; answer checked by next call
   task automatic op(int k, int a, int d);
      @(posedge clock);
      reg_wr <= (k == 1);
      reg_rd <= (k == 2);
      reg_addr <= a[4:0];
      reg_wdata <= d[7:0];
      line_status_in <= $random(seed);
      pin_in <= $random(seed);
      irq_source_in <= rnd ? $random(seed) : sv;
      {carrier_in, ring_in, set_ready_in, clear_to_send_in} <= rnd ? $random(seed) : pv;
      #1;
      if (pk == 1)
         wa(pa, pd[7:0]);
      if (pk == 2 && pe >= 0)
         cmp(reg_rdata, pe[7:0]);
      pk = k;
      pa = a;
      pd = d;
      pe = (k == 2) ? ex(a) : -1;
   endtask
   // watchdog against a hung run
   initial
   begin
      #100000;
      err_count++;
      stop_test;
   end
   // reset, random mix, modem status, interrupt
   initial
   begin
      seed = 40457;
      {rnd, msx, pk, pe} = {1'b1, -32'sd1, 32'd0, -32'sd1};
      foreach (sh[i]) sh[i] = 8'h00;
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, line_status_in, pin_in} = 32'h80000000;
      {carrier_in, ring_in, set_ready_in, clear_to_send_in, pv, sv} = 14'h0001;
      irq_source_in = 6'h01;
      repeat (16) @(posedge clock);
      sys_rst <= 0;
      repeat (1500)
      begin
         k = ($random(seed) & 1) + 1;
         a = $random(seed) & 15;
         d = $random(seed);
         if (a == 3) d = d[9] ? (d[8] ? 8'hBF : d & 8'h7F) : d;
         op(k, a, d);
      end
      op(0, 0, 0);
      $display("random mix done");
      rnd = 0;
      pv = 4'h5;
      op(1, 3, 0);
      op(1, 4, 0);
      repeat (5) op(0, 0, 0);
      op(2, 6, 0);
      repeat (2) op(0, 0, 0);
      msx = {pv, 4'h0};
      op(2, 6, 0);
      pv = pv ^ 4'h3;
      repeat (6) op(0, 0, 0);
      msx = {pv, 4'h3};
      op(2, 6, 0);
      repeat (2) op(0, 0, 0);
      msx = {pv, 4'h0};
      op(2, 6, 0);
      op(0, 0, 0);
      $display("modem status done");
      op(1, 17, 4);
      op(1, 16, 7);
      repeat (3) op(0, 0, 0);
      cmp(irq, 8'h00);
      sv = 6'h00;
      repeat (4) op(0, 0, 0);
      cmp(irq, 8'h01);
      op(1, 17, 0);
      repeat (3) op(0, 0, 0);
      cmp(irq, 8'h00);
      sv = 6'h01;
      op(1, 17, 4);
      repeat (3) op(0, 0, 0);
      cmp(irq, 8'h01);
      op(1, 16, 4);
      repeat (3) op(0, 0, 0);
      cmp(irq, 8'h00);
      $display("interrupt done");
      stop_test;
   end
endmodule
